// ---- core/fscr_pkg.sv ----
// shared constants of the flash status and configuration block
`default_nettype none
package fscr_pkg;
    // opcodes decoded here
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_WR_STAT_LO = 8'h01;
    localparam logic [7:0] OP_WR_STAT_HI = 8'h31;
    localparam logic [7:0] OP_RD_CONFIG = 8'h15;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    // status word bit positions
    localparam int POS_BUSY = 0;
    localparam int POS_WE_LATCH = 1;
    localparam int POS_SP_LOWER = 7;
    localparam int POS_SP_UPPER = 8;
    localparam int POS_QUAD = 9;
    localparam int POS_FAIL = 10;
    localparam int POS_LOCK_LO = 11;
    localparam int POS_CMPL = 14;
    localparam int POS_PAUSED = 15;
    // configuration byte bit positions
    localparam int CFG_HOLD_RST = 7;
    localparam int CFG_DRV_LO = 5;
    localparam int CFG_PAGE_LO = 3;
    localparam int CFG_SCHEME = 2;
    localparam int CFG_DUMMY = 1;
    localparam int CFG_TRAIN = 0;
    // values after reset
    localparam logic [15:0] STAT_RESET = 16'h0000;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // decoded setting values
    localparam logic [7:0] DRV_PCT_00 = 8'h3C;
    localparam logic [7:0] DRV_PCT_01 = 8'h64;
    localparam logic [7:0] DRV_PCT_10 = 8'h8C;
    localparam logic [7:0] DRV_PCT_11 = 8'h28;
    localparam logic [9:0] WRAP_256 = 10'h0FF;
    localparam logic [9:0] WRAP_512 = 10'h1FF;
    localparam logic [9:0] WRAP_1024 = 10'h3FF;
    localparam logic [3:0] DUM_DUAL_0 = 4'h4;
    localparam logic [3:0] DUM_DUAL_1 = 4'h8;
    localparam logic [3:0] DUM_QUAD_0 = 4'h6;
    localparam logic [3:0] DUM_QUAD_1 = 4'hA;
    localparam logic [7:0] TRAIN_PATTERN = 8'h34;
    // serial frame bit counts: legal status write ends and last opcode bit
    localparam logic [5:0] BITS_ONE_BYTE = 6'h10;
    localparam logic [5:0] BITS_TWO_BYTES = 6'h18;
    localparam logic [5:0] BITS_OPCODE_LAST = 6'h07;
    // self-timed status write cycle
    localparam int CLK_MHZ = 25;
    localparam int STAT_WR_TIME_US = 5000;
    localparam int STAT_WR_CYC = STAT_WR_TIME_US * CLK_MHZ;
    localparam int BUSY_CNT_W = 17;
endpackage : fscr_pkg
`default_nettype wire

// ---- core/fscr_link_if.sv ----
// carrier between the serial front end and the register core
`default_nettype none
interface fscr_link_if;
    logic cs_low;
    logic frame_end;
    logic op_valid;
    logic [7:0] op;
    logic [5:0] bit_cnt;
    logic [15:0] rx;
    logic sck_edge;
    logic [7:0] tx_byte;
    logic tx_en;
    logic so_q;
    logic so_oe;
    modport front (output cs_low, frame_end, op_valid, op, bit_cnt, rx, sck_edge, so_q, so_oe,
                   input tx_byte, tx_en);
    modport core (input cs_low, frame_end, op_valid, op, bit_cnt, rx, sck_edge, so_q, so_oe,
                  output tx_byte, tx_en);
endinterface : fscr_link_if
`default_nettype wire

// ---- core/fscr_front.sv ----
// serial front end: pin synchronisers, bit shifter and byte output
`default_nettype none
module fscr_front (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic si_pin,
    fscr_link_if.front lk
);
    import fscr_pkg::*;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_d;
        logic ck_s1;
        logic ck_s2;
        logic ck_d;
        logic si_s1;
        logic si_s2;
        logic [5:0] cnt;
        logic [15:0] sh;
        logic [7:0] op;
        logic op_valid;
        logic frame_end;
        logic [2:0] tx_idx;
        logic so;
        logic so_oe;
    } fscr_front_s;

    fscr_front_s q, d;
    logic rise, fall;

    // edges are taken from the second sync stage only
    always_comb
    begin
        d = q;
        rise = q.ck_s2 & ~q.ck_d;
        fall = ~q.ck_s2 & q.ck_d;
        d.cs_s1 = cs_n_pin;
        d.cs_s2 = q.cs_s1;
        d.cs_d = q.cs_s2;
        d.ck_s1 = sclk_pin;
        d.ck_s2 = q.ck_s1;
        d.ck_d = q.ck_s2;
        d.si_s1 = si_pin;
        d.si_s2 = q.si_s1;
        d.op_valid = 1'b0;
        d.frame_end = q.cs_s2 & ~q.cs_d;
        if (q.cs_s2)
        begin
            // count survives the frame-end cycle so the core can judge the length
            if (q.cs_d)
                d.cnt = '0;
            d.tx_idx = '0;
            d.so_oe = 1'b0;
        end
        else
        begin
            if (rise)
            begin
                d.sh = {q.sh[14:0], q.si_s2};
                // saturate so long frames never alias a legal count
                if (q.cnt != 6'h3F)
                    d.cnt = q.cnt + 6'h01;
                if (q.cnt == BITS_OPCODE_LAST)
                begin
                    d.op = {q.sh[6:0], q.si_s2};
                    d.op_valid = 1'b1;
                end
            end
            // data leaves on the falling edge, msb first, byte repeats
            if (fall && lk.tx_en)
            begin
                d.so = lk.tx_byte[3'h7 - q.tx_idx];
                d.tx_idx = q.tx_idx + 3'h1;
                d.so_oe = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1, default: '0};
        else
            q <= d;
    end

    // outputs toward the core
    assign lk.cs_low = ~q.cs_s2;
    assign lk.frame_end = q.frame_end;
    assign lk.op_valid = q.op_valid;
    assign lk.op = q.op;
    assign lk.bit_cnt = q.cnt;
    assign lk.rx = q.sh;
    assign lk.sck_edge = q.ck_s2 ^ q.ck_d;
    assign lk.so_q = q.so;
    assign lk.so_oe = q.so_oe;
endmodule : fscr_front
`default_nettype wire

// ---- core/fscr_regs.sv ----
// status word and configuration byte logic of a serial nor flash
// Summary of operation
// - three security lock bits start clear, set individually, never clear again
// - protection complement bit is writable, defaults clear, joins block protect decode
// - paused flag set by suspend opcode, cleared by resume opcode or reset
// - configuration read opcode is served at any time, even while busy
// - configuration read drives the byte on serial output, upper lines ignored
// - with quad off, config bit seven picks hold or reset for shared pin
// - with quad on, shared pin carries data only, hold and reset disabled
// - drive strength field selects sixty, hundred, hundred forty or forty percent
// - page size field selects 256, 512 or 1024 byte program page
// - program buffer load address wraps at the selected page size
// - page erase covers one, two or four pages by page size field
// - scheme bit picks area protection or individual block locks
// - all individual block lock bits preset to one after any reset
// - dummy bit sets dual read four or eight, quad read six or ten
// - training enable drives pattern 00110100 on all lines during dummy cycles
// - status write opcode 01H updates low byte, 31H updates high byte
// - status write needs the write enable latch set first
// - status write data never lands in bits fifteen, ten, one and zero
// - status write counts only if chip select rises after bit 8 or 16
// - one byte status write with opcode 01H clears complement, quad and upper protect bits
// - valid status write starts timed busy cycle, then latch clears
// - hardware protected mode refuses status writes
// - lower protect set with write protect pin low locks both registers
// - latch clear means status write, program and erase are refused
`default_nettype none
module fscr_regs #(
    parameter int STAT_WR_CYCLES = fscr_pkg::STAT_WR_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic si_pin,
    output logic so_out,
    output logic so_oe,
    input wire logic wp_n_pin,
    input wire logic hold_rst_n_pin,
    input wire logic ep_fail_in,
    input wire logic train_window,
    input wire logic cfg_wr_valid,
    input wire logic [7:0] cfg_wr_data,
    output logic [3:0] training_out,
    output logic training_oe,
    output logic [15:0] status_word,
    output logic [7:0] configuration_byte,
    output logic busy_flag,
    output logic write_enable_latch,
    output logic protect_complement,
    output logic protect_scheme_select,
    output logic block_lock_preset,
    output logic hold_active,
    output logic reset_active,
    output logic [7:0] drive_strength_pct,
    output logic [9:0] page_wrap_mask,
    output logic [2:0] erase_page_count,
    output logic [3:0] dummy_dual,
    output logic [3:0] dummy_quad
);
    import fscr_pkg::*;

    typedef struct packed {
        logic [15:0] stat;
        logic [7:0] cfg;
        logic armed;
        logic arm_hi;
        logic rd_cfg;
        logic [BUSY_CNT_W-1:0] busy_cnt;
        logic wp_s1;
        logic wp_s2;
        logic hr_s1;
        logic hr_s2;
        logic [2:0] tr_idx;
        logic tr_bit;
        logic tr_oe;
        logic hold_q;
        logic rst_act;
        logic preset;
        logic [7:0] drv_pct;
        logic [9:0] wrap_mask;
        logic [2:0] pages;
        logic [3:0] dum_dual;
        logic [3:0] dum_quad;
    } fscr_core_s;

    localparam fscr_core_s CORE_RST = '{stat: STAT_RESET, cfg: CFG_RESET, wp_s1: 1'b1, wp_s2: 1'b1,
                                       hr_s1: 1'b1, hr_s2: 1'b1, preset: 1'b1, drv_pct: DRV_PCT_00,
                                       wrap_mask: WRAP_256, pages: 3'h1, dum_dual: DUM_DUAL_0,
                                       dum_quad: DUM_QUAD_0, default: '0};

    logic rs1, rs2, rst_n;
    fscr_core_s q, d;
    fscr_link_if lk ();
    logic hw_prot, wr_op, frame_ok, start_wr, one_byte;
    logic [7:0] lo_b, hi_b;

    // reset release passes two flops; assertion stays asynchronous
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rs1 <= 1'b0;
            rs2 <= 1'b0;
        end
        else
        begin
            rs1 <= 1'b1;
            rs2 <= rs1;
        end
    end
    assign rst_n = rs2;

    fscr_front u_front (
        .clk(ref_clk),
        .rst_n(rst_n),
        .cs_n_pin(cs_n_pin),
        .sclk_pin(sclk_pin),
        .si_pin(si_pin),
        .lk(lk)
    );

    // protect mode and frame-end qualification
    always_comb
    begin
        hw_prot = q.stat[POS_SP_UPPER] | (q.stat[POS_SP_LOWER] & ~q.wp_s2);
        wr_op = lk.op_valid && (lk.op == OP_WR_STAT_LO || lk.op == OP_WR_STAT_HI);
        // only bit 8 or bit 16 of data is a legal end
        frame_ok = lk.bit_cnt == BITS_ONE_BYTE || lk.bit_cnt == BITS_TWO_BYTES;
        start_wr = lk.frame_end && q.armed && frame_ok;
        one_byte = lk.bit_cnt == BITS_ONE_BYTE;
        lo_b = one_byte ? lk.rx[7:0] : lk.rx[15:8];
        hi_b = lk.rx[7:0];
    end

    // next state of the whole register core
    always_comb
    begin
        d = q;
        d.wp_s1 = wp_n_pin;
        d.wp_s2 = q.wp_s1;
        d.hr_s1 = hold_rst_n_pin;
        d.hr_s2 = q.hr_s1;
        d.stat[POS_FAIL] = ep_fail_in;
        // opcode decode, one pulse per frame
        if (lk.op_valid)
        begin
            case (lk.op)
                OP_WR_ENABLE:
                    if (!q.stat[POS_BUSY])
                        d.stat[POS_WE_LATCH] = 1'b1;
                OP_WR_DISABLE:
                    if (!q.stat[POS_BUSY])
                        d.stat[POS_WE_LATCH] = 1'b0;
                // suspend and resume drive the paused flag
                OP_SUSPEND:
                    d.stat[POS_PAUSED] = 1'b1;
                OP_RESUME:
                    d.stat[POS_PAUSED] = 1'b0;
                OP_RD_CONFIG:
                    d.rd_cfg = 1'b1;
                default:
                    d.rd_cfg = q.rd_cfg;
            endcase
        end
        // latch, busy and protect gate the write
        if (wr_op)
        begin
            d.armed = q.stat[POS_WE_LATCH] & ~q.stat[POS_BUSY] & ~hw_prot;
            d.arm_hi = lk.op == OP_WR_STAT_HI;
        end
        // output repeats until the frame closes
        if (lk.frame_end)
        begin
            d.rd_cfg = 1'b0;
            d.armed = 1'b0;
        end
        if (start_wr)
        begin
            // opcode picks the byte that is written
            if (q.arm_hi)
            begin
                // lock bits only accumulate, 15 and 10 kept
                d.stat[POS_CMPL] = lo_b[6];
                d.stat[13:11] = q.stat[13:11] | lo_b[5:3];
                d.stat[POS_QUAD] = lo_b[1];
                d.stat[POS_SP_UPPER] = lo_b[0];
            end
            else
            begin
                // bits one and zero are never taken from data
                d.stat[7:2] = lo_b[7:2];
                if (one_byte)
                begin
                    // legacy one byte write clears three bits
                    d.stat[POS_CMPL] = 1'b0;
                    d.stat[POS_QUAD] = 1'b0;
                    d.stat[POS_SP_UPPER] = 1'b0;
                end
                else
                begin
                    d.stat[POS_CMPL] = hi_b[6];
                    d.stat[13:11] = q.stat[13:11] | hi_b[5:3];
                    d.stat[POS_QUAD] = hi_b[1];
                    d.stat[POS_SP_UPPER] = hi_b[0];
                end
            end
            // timed cycle begins at chip select rise
            d.stat[POS_BUSY] = 1'b1;
            d.busy_cnt = BUSY_CNT_W'(STAT_WR_CYCLES - 1);
        end
        else if (q.stat[POS_BUSY])
        begin
            // busy ends and the latch drops together
            if (q.busy_cnt == '0)
            begin
                d.stat[POS_BUSY] = 1'b0;
                d.stat[POS_WE_LATCH] = 1'b0;
            end
            else
                d.busy_cnt = q.busy_cnt - BUSY_CNT_W'(1);
        end
        // configuration writes obey the same hardware lock
        if (cfg_wr_valid && !hw_prot)
            d.cfg = cfg_wr_data;
        // shared pin role, quad mode turns both off
        d.hold_q = ~q.stat[POS_QUAD] & ~q.cfg[CFG_HOLD_RST] & ~q.hr_s2;
        d.rst_act = ~q.stat[POS_QUAD] & q.cfg[CFG_HOLD_RST] & ~q.hr_s2;
        // block locks preset after reset or reset pin
        d.preset = d.rst_act;
        case (q.cfg[CFG_DRV_LO+1:CFG_DRV_LO])
            2'h1: d.drv_pct = DRV_PCT_01;
            2'h2: d.drv_pct = DRV_PCT_10;
            2'h3: d.drv_pct = DRV_PCT_11;
            default: d.drv_pct = DRV_PCT_00;
        endcase
        // page size, wrap and erase span
        case (q.cfg[CFG_PAGE_LO+1:CFG_PAGE_LO])
            2'h1:
            begin
                d.wrap_mask = WRAP_512;
                d.pages = 3'h2;
            end
            2'h2:
            begin
                d.wrap_mask = WRAP_1024;
                d.pages = 3'h4;
            end
            default:
            begin
                d.wrap_mask = WRAP_256;
                d.pages = 3'h1;
            end
        endcase
        d.dum_dual = q.cfg[CFG_DUMMY] ? DUM_DUAL_1 : DUM_DUAL_0;
        d.dum_quad = q.cfg[CFG_DUMMY] ? DUM_QUAD_1 : DUM_QUAD_0;
        // pattern advances on both clock edges of a dtr dummy phase
        if (train_window && q.cfg[CFG_TRAIN])
        begin
            d.tr_oe = 1'b1;
            if (lk.sck_edge || !q.tr_oe)
            begin
                d.tr_bit = TRAIN_PATTERN[3'h7 - q.tr_idx];
                d.tr_idx = q.tr_idx + 3'h1;
            end
        end
        else
        begin
            d.tr_oe = 1'b0;
            d.tr_idx = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= CORE_RST;
        else
            q <= d;
    end

    // configuration byte feeds the serial shifter
    assign lk.tx_byte = q.cfg;
    assign lk.tx_en = q.rd_cfg;
    assign so_out = lk.so_q;
    assign so_oe = lk.so_oe;
    // register outputs
    assign training_out = {4{q.tr_bit}};
    assign training_oe = q.tr_oe;
    assign status_word = q.stat;
    assign configuration_byte = q.cfg;
    assign busy_flag = q.stat[POS_BUSY];
    assign write_enable_latch = q.stat[POS_WE_LATCH];
    assign protect_complement = q.stat[POS_CMPL];
    // scheme select drives protection choice outside
    assign protect_scheme_select = q.cfg[CFG_SCHEME];
    assign block_lock_preset = q.preset;
    assign hold_active = q.hold_q;
    assign reset_active = q.rst_act;
    assign drive_strength_pct = q.drv_pct;
    assign page_wrap_mask = q.wrap_mask;
    assign erase_page_count = q.pages;
    assign dummy_dual = q.dum_dual;
    assign dummy_quad = q.dum_quad;

    // checks beside the logic
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_LOCK_STICKY: assert property (($past(q.stat[13:11]) & ~q.stat[13:11]) == 3'h0)
        else $error("security lock bit returned to zero");
    AST_PAUSE_SET: assert property (lk.op_valid && lk.op == OP_SUSPEND |=> q.stat[POS_PAUSED])
        else $error("suspend did not set paused flag");
    AST_RDCFG_ANY: assert property (lk.op_valid && lk.op == OP_RD_CONFIG |=> q.rd_cfg)
        else $error("configuration read not taken");
    AST_NEEDS_LATCH: assert property (wr_op && !q.stat[POS_WE_LATCH] |=> !q.armed)
        else $error("status write armed without latch");
    AST_KEEP_TOP: assert property (start_wr |=> q.stat[POS_PAUSED] == $past(q.stat[POS_PAUSED]))
        else $error("status write changed paused flag");
    AST_BAD_END: assert property (lk.frame_end && !frame_ok && !q.stat[POS_BUSY] |=> !q.stat[POS_BUSY])
        else $error("bad frame length started a write");
    AST_ONE_BYTE: assert property (start_wr && !q.arm_hi && one_byte
                                   |=> !q.stat[POS_CMPL] && !q.stat[POS_QUAD]
                                       && !q.stat[POS_SP_UPPER])
        else $error("one byte write left bits set");
    AST_BUSY_HOLD: assert property (start_wr |=> q.stat[POS_BUSY] [*8])
        else $error("busy dropped early");
    AST_BUSY_END: assert property (q.stat[POS_BUSY] && q.busy_cnt == '0 && !start_wr
                                   |=> !q.stat[POS_BUSY] && !q.stat[POS_WE_LATCH])
        else $error("busy end did not clear latch");
    AST_HW_LOCK: assert property (wr_op && hw_prot |=> !q.armed)
        else $error("write armed in hardware protect");
    AST_QUAD_PIN: assert property (q.stat[POS_QUAD] ##1 q.stat[POS_QUAD] |=> !hold_active && !reset_active)
        else $error("shared pin active in quad mode");
endmodule : fscr_regs
`default_nettype wire

// ---- tb/fscr_host_model.sv ----
// spi host model: drives chip select, serial clock and data in
`default_nettype none
module fscr_host_model (
    input wire logic clk,
    output logic cs_n,
    output logic sclk,
    output logic si,
    input wire logic so
);
    timeunit 1ns;
    timeprecision 1ps;
    // link parks with clock low and select high between frames
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    // one mode 0 frame, 320 ns serial period; rd keeps the last 16 bits seen
    task automatic xfer(input logic [7:0] op, input logic [15:0] dat, input int nd, output logic [15:0] rd);
        logic [23:0] sh;
        sh = {op, dat};
        rd = 16'h0000;
        @(posedge clk);
        #1 cs_n = 1'b0;
        for (int i = 0; i < 8 + nd; i++)
        begin
            si = sh[23 - i];
            repeat (4) @(posedge clk);
            #1 sclk = 1'b1;
            rd = {rd[14:0], so};
            repeat (4) @(posedge clk);
            #1 sclk = 1'b0;
        end
        repeat (4) @(posedge clk);
        // select rises right after the last bit given
        #1 cs_n = 1'b1;
        si = ~si; // released line: never leave the last value standing
        repeat (8) @(posedge clk);
    endtask
endmodule // fscr_host_model
`default_nettype wire

// ---- tb/fscr_regs_test.sv ----
// self-checking bench of the status and configuration register block
`default_nettype none
module fscr_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import fscr_pkg::*;
    logic ref_clk, resetn, cs_n, sclk, si, so_out, so_oe, wp_n, hold_n, ep_fail, train_window, cfg_wr_valid;
    logic [7:0] cfg_wr_data, configuration_byte, drive_strength_pct;
    logic [3:0] training_out, dummy_dual, dummy_quad;
    logic [15:0] status_word, rd;
    logic training_oe, busy_flag, write_enable_latch, protect_complement, protect_scheme_select;
    logic block_lock_preset, hold_active, reset_active;
    logic [9:0] page_wrap_mask;
    logic [2:0] erase_page_count;
    int mismatches = 0;
    int samples_checked = 0;
    // short status write cycle keeps the run brief
    fscr_regs #(.STAT_WR_CYCLES(200)) dut (.ref_clk(ref_clk), .resetn(resetn), .cs_n_pin(cs_n), .sclk_pin(sclk),
        .si_pin(si), .so_out(so_out), .so_oe(so_oe), .wp_n_pin(wp_n), .hold_rst_n_pin(hold_n),
        .ep_fail_in(ep_fail), .train_window(train_window), .cfg_wr_valid(cfg_wr_valid),
        .cfg_wr_data(cfg_wr_data), .training_out(training_out), .training_oe(training_oe),
        .status_word(status_word), .configuration_byte(configuration_byte), .busy_flag(busy_flag),
        .write_enable_latch(write_enable_latch), .protect_complement(protect_complement),
        .protect_scheme_select(protect_scheme_select), .block_lock_preset(block_lock_preset),
        .hold_active(hold_active), .reset_active(reset_active), .drive_strength_pct(drive_strength_pct),
        .page_wrap_mask(page_wrap_mask), .erase_page_count(erase_page_count), .dummy_dual(dummy_dual),
        .dummy_quad(dummy_quad));
    // a released output shows the inverse so a read of an undriven line cannot pass
    fscr_host_model host (.clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so_oe ? so_out : ~so_out));
    // free running 25 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cfg_wr(input logic [7:0] d);
        @(posedge ref_clk);
        #1 cfg_wr_data = d;
        cfg_wr_valid = 1'b1;
        @(posedge ref_clk);
        #1 cfg_wr_valid = 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    // write enable frame, then the status write frame
    task automatic wr_status(input logic [7:0] op, input logic [15:0] dat, input int nd);
        host.xfer(OP_WR_ENABLE, 16'h0000, 0, rd);
        chk(16'(write_enable_latch), 16'h0001);
        host.xfer(op, dat, nd, rd);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy_flag !== 1'b0 && n < 600)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk(16'(busy_flag), 16'h0000);
        chk(16'(write_enable_latch), 16'h0000);
    endtask
    // watchdog well past the expected few thousand cycles
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        mismatches++;
        results();
    end
    // test sequence
    initial
    begin
        // dummy window held open so a cleared training bit is seen to stay silent
        {resetn, wp_n, hold_n, ep_fail, train_window, cfg_wr_valid, cfg_wr_data} = {6'b011010, 8'h00};
        repeat (4) @(posedge ref_clk);
        chk(16'(block_lock_preset), 16'h0001);
        #1 resetn = 1'b1;
        repeat (6) @(posedge ref_clk);
        chk(status_word, 16'h0000);
        chk({8'h00, configuration_byte}, 16'h0000);
        $display("reset values done");
        // every drive, page and dummy code, reserved page code included
        for (int i = 0; i < 4; i++)
        begin
            cfg_wr({1'b0, 2'(i), 2'(i), 1'(i), 1'(i), 1'b0});
            chk({8'h00, drive_strength_pct}, i == 0 ? 16'h3C : i == 1 ? 16'h64 : i == 2 ? 16'h8C : 16'h28);
            chk({6'h00, page_wrap_mask}, i == 1 ? 16'h1FF : i == 2 ? 16'h3FF : 16'h0FF);
            chk({13'h0, erase_page_count}, i == 1 ? 16'h2 : i == 2 ? 16'h4 : 16'h1);
            chk({8'h00, dummy_quad, dummy_dual}, i % 2 == 1 ? 16'hA8 : 16'h64);
            chk(16'(protect_scheme_select), 16'(i % 2));
            chk(16'(training_oe), 16'h0000);
        end
        cfg_wr(8'h4B);
        #1 train_window = 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({11'h0, training_oe, training_out}, 16'h0010);
        #1 train_window = 1'b0;
        host.xfer(OP_RD_CONFIG, 16'h0000, 16, rd);
        chk(rd, 16'h4B4B);
        chk(16'(so_oe), 16'h0000);
        $display("configuration tests done");
        host.xfer(OP_WR_STAT_LO, 16'hFF00, 8, rd);
        chk(16'(busy_flag), 16'h0000);
        chk(status_word, 16'h0000);
        wr_status(OP_WR_STAT_LO, 16'hFF00, 8);
        chk(16'(busy_flag), 16'h0001);
        host.xfer(OP_RD_CONFIG, 16'h0000, 8, rd);
        chk({8'h00, rd[7:0]}, 16'h004B);
        wait_idle();
        chk(status_word, 16'h00FC);
        wr_status(OP_WR_STAT_HI, 16'hFE00, 16);
        wait_idle();
        chk(status_word, 16'h7AFC);
        chk(16'(protect_complement), 16'h0001);
        // quad on: shared pin has neither hold nor reset role
        #1 hold_n = 1'b0;
        cfg_wr(8'hCB);
        chk({hold_active, reset_active}, 16'h0000);
        #1 hold_n = 1'b1;
        cfg_wr(8'h4B);
        host.xfer(OP_WR_ENABLE, 16'h0000, 0, rd);
        host.xfer(OP_WR_STAT_LO, 16'h0F00, 12, rd);
        chk(16'(busy_flag), 16'h0000);
        chk({status_word[15:2], 2'b00}, 16'h7AFC);
        host.xfer(OP_WR_DISABLE, 16'h0000, 0, rd);
        wr_status(OP_WR_STAT_LO, 16'h0000, 8);
        wait_idle();
        chk(status_word, 16'h3800);
        $display("status write tests done");
        host.xfer(OP_SUSPEND, 16'h0000, 0, rd);
        chk(16'(status_word[15]), 16'h0001);
        host.xfer(OP_RESUME, 16'h0000, 0, rd);
        chk(16'(status_word[15]), 16'h0000);
        $display("suspend tests done");
        wr_status(OP_WR_STAT_LO, 16'h8000, 8);
        wait_idle();
        #1 wp_n = 1'b0;
        wr_status(OP_WR_STAT_LO, 16'h0400, 8);
        chk(16'(busy_flag), 16'h0000);
        chk(status_word, 16'h3882);
        cfg_wr(8'h00);
        chk({8'h00, configuration_byte}, 16'h004B);
        #1 wp_n = 1'b1;
        $display("protection tests done");
        // shared pin roles last, since a reset role may clear state
        #1 hold_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        chk({hold_active, reset_active}, 16'h0002);
        #1 hold_n = 1'b1;
        cfg_wr(8'hCB);
        #1 hold_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        chk({hold_active, reset_active, block_lock_preset}, 16'h0003);
        $display("pin role tests done");
        results();
    end
endmodule // fscr_regs_test
`default_nettype wire
